// *** logic/dplc_pkg.sv ***
// constants and types shared by the defect pixel list block
package dplc_pkg;
  // list geometry
  localparam int LIST_DEPTH = 1000;
  localparam int IDX_W = 10;
  localparam int COL_W = 13;
  localparam int ROW_W = 13;
  localparam int KEY_W = ROW_W + COL_W;
  localparam int PIX_W = 10;
  localparam logic [IDX_W-1:0] LIST_MAX = 10'h3e8;
  localparam logic [IDX_W-1:0] FACT_MAX = 10'h2bc;
  localparam logic [IDX_W-1:0] IDX_MAX = 10'h3e8;
  localparam logic [IDX_W-1:0] IDX_ONE = 10'h001;
  // pixel levels used for marking
  localparam logic [PIX_W-1:0] PIX_WHITE = 10'h3ff;
  localparam logic [PIX_W-1:0] PIX_BLACK = 10'h000;

  typedef enum logic [1:0] {
    TM_OFF = 2'b00,
    TM_MARK_WHITE_LIVE = 2'b01,
    TM_MARK_BLACK_LIVE = 2'b10,
    TM_SYNTHETIC_MAP_PATTERN = 2'b11
  } dplc_tmode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FIND = 3'b001,
    ST_SHUP = 3'b010,
    ST_SHDN = 3'b011,
    ST_LDA = 3'b100,
    ST_LDD = 3'b101
  } dplc_state_t;
endpackage : dplc_pkg

// *** logic/dplc_list_mem.sv ***
// coordinate list storage: one write port, three asynchronous read ports
module dplc_list_mem (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [dplc_pkg::IDX_W-1:0] wr_addr,
  input wire logic [dplc_pkg::KEY_W-1:0] wr_data,
  input wire logic [dplc_pkg::IDX_W-1:0] cmd_addr,
  output logic [dplc_pkg::KEY_W-1:0] cmd_data,
  input wire logic [dplc_pkg::IDX_W-1:0] str_addr,
  output logic [dplc_pkg::KEY_W-1:0] str_data,
  input wire logic [dplc_pkg::IDX_W-1:0] rd_addr,
  output logic [dplc_pkg::KEY_W-1:0] rd_data
);
  import dplc_pkg::*;

  logic [KEY_W-1:0] mem [0:LIST_DEPTH-1];

  // entries are not reset; the entry count says which are valid
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // reads beyond the count are masked by the reader
  assign cmd_data = mem[cmd_addr];
  assign str_data = mem[str_addr];
  assign rd_data = mem[rd_addr];
endmodule : dplc_list_mem

// *** logic/dplc_pix_out.sv ***
// output pixel stage: correction, live marking and the synthetic map
module dplc_pix_out (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic correction_enable,
  input wire logic [1:0] test_display_select,
  input wire logic pix_valid_in,
  input wire logic pix_sof_in,
  input wire logic pix_eol_in,
  input wire logic [dplc_pkg::PIX_W-1:0] pix_data_in,
  input wire logic hit,
  output logic pix_valid_out,
  output logic pix_sof_out,
  output logic pix_eol_out,
  output logic [dplc_pkg::PIX_W-1:0] pix_data_out
);
  import dplc_pkg::*;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eol;
    logic [PIX_W-1:0] data;
    logic [PIX_W-1:0] prev;
    logic prev_ok;
  } dplc_pix_t;

  dplc_pix_t s_r, s_nxt;
  logic [PIX_W-1:0] fix;

  // left neighbour replaces a defect; first pixel of a line keeps its own value
  always_comb begin
    s_nxt = s_r;
    fix = (s_r.prev_ok && !pix_sof_in) ? s_r.prev : pix_data_in;
    s_nxt.valid = pix_valid_in;
    s_nxt.sof = pix_valid_in & pix_sof_in;
    s_nxt.eol = pix_valid_in & pix_eol_in;
    if (pix_valid_in) begin
      unique case (test_display_select)
        TM_OFF: s_nxt.data = (hit && correction_enable) ? fix : pix_data_in;
        TM_MARK_WHITE_LIVE: s_nxt.data = hit ? PIX_WHITE : pix_data_in;
        TM_MARK_BLACK_LIVE: s_nxt.data = hit ? PIX_BLACK : pix_data_in;
        TM_SYNTHETIC_MAP_PATTERN: s_nxt.data = hit ? PIX_WHITE : PIX_BLACK;
      endcase
      s_nxt.prev = hit ? fix : pix_data_in;
      s_nxt.prev_ok = !pix_eol_in;
    end
  end

  // register the whole stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pix_valid_out = s_r.valid;
  assign pix_sof_out = s_r.sof;
  assign pix_eol_out = s_r.eol;
  assign pix_data_out = s_r.data;

  a_corr_off_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pix_valid_in && test_display_select == TM_OFF && !correction_enable)
    |=> pix_data_out == $past(pix_data_in))
    else $error("uncorrected pixel altered");
  a_mark_white_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pix_valid_in && test_display_select == TM_MARK_WHITE_LIVE && hit) |=> pix_data_out == PIX_WHITE)
    else $error("listed pixel not marked white");
  a_pattern_black: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pix_valid_in && test_display_select == TM_SYNTHETIC_MAP_PATTERN && !hit)
    ##1 pix_valid_out |-> pix_data_out == PIX_BLACK)
    else $error("pattern background not black");
endmodule : dplc_pix_out

// *** logic/dplc_top.sv ***
// defect pixel list: command engine, readouts and stream matching
// Contract
// - list holds at most 1000 coordinate entries
// - factory list loads are limited to 700 entries
// - correction enabled corrects listed pixels; disabled applies none; the code leaves a listed first pixel of a line uncorrected
// - test mode off passes video; mark-white turns listed pixels white
// - mark-black turns listed pixels black on live video
// - pattern mode outputs listed positions white on black, no video
// - entry count output equals entries in the list
// - entry count refreshed after add, remove, clear, both restores
// - read index accepts 0 to 1000 and selects readout entry
// - read index updated after add, remove, clear, factory restore
// - column readout shows selected entry's column
// - row readout shows selected entry's row
// - readouts refresh on index change and list-altering commands
// - write column accepted from zero to array columns minus one
// - write row accepted from zero to array rows minus one
// - add inserts the held write coordinate pair at its place in scan order
// - remove deletes the entry matching the held coordinate pair
// - clear empties the list, count becomes zero
// - user restore replaces the list with the saved user list
// - factory restore replaces the list with the factory list
module dplc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic correction_enable,
  input wire logic [1:0] test_display_select,
  input wire logic [dplc_pkg::COL_W-1:0] array_columns,
  input wire logic [dplc_pkg::ROW_W-1:0] array_rows,
  input wire logic [dplc_pkg::COL_W-1:0] write_column,
  input wire logic [dplc_pkg::ROW_W-1:0] write_row,
  input wire logic append_entry_cmd,
  input wire logic delete_entry_cmd,
  input wire logic empty_list_cmd,
  input wire logic load_user_list_cmd,
  input wire logic load_factory_list_cmd,
  input wire logic read_index_wr,
  input wire logic [dplc_pkg::IDX_W-1:0] read_index_in,
  output logic [dplc_pkg::IDX_W-1:0] read_index,
  output logic [dplc_pkg::IDX_W-1:0] entry_count,
  output logic [dplc_pkg::COL_W-1:0] read_column,
  output logic [dplc_pkg::ROW_W-1:0] read_row,
  output logic list_busy,
  input wire logic [dplc_pkg::IDX_W-1:0] nvm_user_count,
  input wire logic [dplc_pkg::IDX_W-1:0] nvm_factory_count,
  output logic nvm_factory_sel,
  output logic [dplc_pkg::IDX_W-1:0] nvm_rd_addr,
  input wire logic [dplc_pkg::KEY_W-1:0] nvm_rd_data,
  input wire logic pix_valid_in,
  input wire logic pix_sof_in,
  input wire logic pix_eol_in,
  input wire logic [dplc_pkg::PIX_W-1:0] pix_data_in,
  output logic pix_valid_out,
  output logic pix_sof_out,
  output logic pix_eol_out,
  output logic [dplc_pkg::PIX_W-1:0] pix_data_out
);
  import dplc_pkg::*;

  typedef struct packed {
    dplc_state_t st;
    logic del;
    logic busy;
    logic [IDX_W-1:0] cnt;
    logic [IDX_W-1:0] i;
    logic [IDX_W-1:0] j;
    logic [IDX_W-1:0] pos;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] nv_addr;
    logic [IDX_W-1:0] nv_n;
    logic nv_fact;
    logic [COL_W-1:0] wcol;
    logic [ROW_W-1:0] wrow;
    logic [COL_W-1:0] rcol;
    logic [ROW_W-1:0] rrow;
    logic [COL_W-1:0] ccol;
    logic [ROW_W-1:0] crow;
    logic [IDX_W-1:0] ptr;
  } dplc_ctl_t;

  dplc_ctl_t s_r, s_nxt;
  logic we;
  logic [IDX_W-1:0] wa;
  logic [IDX_W-1:0] ca;
  logic [IDX_W-1:0] pp;
  logic [KEY_W-1:0] wd;
  logic [KEY_W-1:0] ce;
  logic [KEY_W-1:0] se;
  logic [KEY_W-1:0] re;
  logic [KEY_W-1:0] wkey;
  logic [KEY_W-1:0] pkey;
  logic [COL_W-1:0] pc;
  logic [ROW_W-1:0] pr;
  logic in_rng;
  logic hit;

  // raster keys: row in the high bits keeps the list in scan order
  assign wkey = {s_r.wrow, s_r.wcol};
  assign in_rng = (write_column < array_columns) && (write_row < array_rows);
  assign pc = pix_sof_in ? '0 : s_r.ccol;
  assign pr = pix_sof_in ? '0 : s_r.crow;
  assign pp = pix_sof_in ? '0 : s_r.ptr;
  assign pkey = {pr, pc};
  assign hit = pix_valid_in && (pp < s_r.cnt) && (se == pkey);

  dplc_list_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(we),
    .wr_addr(wa),
    .wr_data(wd),
    .cmd_addr(ca),
    .cmd_data(ce),
    .str_addr(pp),
    .str_data(se),
    .rd_addr(s_r.idx),
    .rd_data(re)
  );

  // command engine, readouts and raster tracking
  always_comb begin
    s_nxt = s_r;
    we = 1'b0;
    wa = s_r.j;
    wd = ce;
    ca = s_r.i;
    unique case (s_r.st)
      ST_IDLE: begin
        if (append_entry_cmd) begin
          if (in_rng && s_r.cnt != LIST_MAX) begin
            s_nxt.st = ST_FIND;
            s_nxt.del = 1'b0;
            s_nxt.busy = 1'b1;
            s_nxt.i = '0;
            s_nxt.wcol = write_column;
            s_nxt.wrow = write_row;
          end
        end else if (delete_entry_cmd) begin
          s_nxt.st = ST_FIND;
          s_nxt.del = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.i = '0;
          s_nxt.wcol = write_column;
          s_nxt.wrow = write_row;
        end else if (empty_list_cmd) begin
          s_nxt.cnt = '0;
          s_nxt.idx = '0;
        end else if (load_user_list_cmd) begin
          s_nxt.nv_fact = 1'b0;
          s_nxt.nv_n = (nvm_user_count > LIST_MAX) ? LIST_MAX : nvm_user_count;
          s_nxt.cnt = '0;
          s_nxt.j = '0;
          s_nxt.st = (nvm_user_count == '0) ? ST_IDLE : ST_LDA;
          s_nxt.busy = (nvm_user_count != '0);
        end else if (load_factory_list_cmd) begin
          s_nxt.nv_fact = 1'b1;
          s_nxt.nv_n = (nvm_factory_count > FACT_MAX) ? FACT_MAX : nvm_factory_count;
          s_nxt.cnt = '0;
          s_nxt.idx = '0;
          s_nxt.j = '0;
          s_nxt.st = (nvm_factory_count == '0) ? ST_IDLE : ST_LDA;
          s_nxt.busy = (nvm_factory_count != '0);
        end else if (read_index_wr && read_index_in <= IDX_MAX) begin
          s_nxt.idx = read_index_in;
        end
      end
      ST_FIND: begin
        // walk the sorted list for the insert point or the match
        if (s_r.i == s_r.cnt || ce > wkey) begin
          if (s_r.del) begin
            s_nxt.st = ST_IDLE; // no such entry
            s_nxt.busy = 1'b0;
          end else begin
            s_nxt.pos = s_r.i;
            s_nxt.j = s_r.cnt;
            s_nxt.st = ST_SHUP;
          end
        end else if (ce == wkey) begin
          if (s_r.del) begin
            s_nxt.pos = s_r.i;
            s_nxt.j = s_r.i;
            s_nxt.st = ST_SHDN;
          end else begin
            s_nxt.st = ST_IDLE; // already listed
            s_nxt.busy = 1'b0;
          end
        end else begin
          s_nxt.i = s_r.i + IDX_ONE;
        end
      end
      ST_SHUP: begin
        // open a gap from the top down, then drop the new pair in
        ca = s_r.j - IDX_ONE;
        we = 1'b1;
        if (s_r.j == s_r.pos) begin
          wd = wkey;
          s_nxt.cnt = s_r.cnt + IDX_ONE;
          s_nxt.idx = s_r.pos;
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
        end else begin
          s_nxt.j = s_r.j - IDX_ONE;
        end
      end
      ST_SHDN: begin
        // close the gap left by the removed entry
        ca = s_r.j + IDX_ONE;
        if (s_r.j + IDX_ONE == s_r.cnt) begin
          s_nxt.cnt = s_r.cnt - IDX_ONE;
          s_nxt.idx = '0;
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
        end else begin
          we = 1'b1;
          s_nxt.j = s_r.j + IDX_ONE;
        end
      end
      ST_LDA: begin
        s_nxt.nv_addr = s_r.j;
        s_nxt.st = ST_LDD;
      end
      ST_LDD: begin
        // stored lists are taken as already in scan order
        we = 1'b1;
        wd = nvm_rd_data;
        if (s_r.j + IDX_ONE == s_r.nv_n) begin
          s_nxt.cnt = s_r.nv_n;
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
        end else begin
          s_nxt.j = s_r.j + IDX_ONE;
          s_nxt.st = ST_LDA;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
    // readouts follow the selected entry every cycle
    if (s_r.idx < s_r.cnt) begin
      s_nxt.rcol = re[COL_W-1:0];
      s_nxt.rrow = re[KEY_W-1:COL_W];
    end else begin
      s_nxt.rcol = '0;
      s_nxt.rrow = '0;
    end
    // raster position and list pointer for the incoming pixel
    if (pix_valid_in) begin
      s_nxt.ccol = pix_eol_in ? '0 : pc + 1'b1;
      s_nxt.crow = pix_eol_in ? pr + 1'b1 : pr;
      s_nxt.ptr = (pp < s_r.cnt && se <= pkey) ? pp + IDX_ONE : pp;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  dplc_pix_out u_pix (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .correction_enable(correction_enable),
    .test_display_select(test_display_select),
    .pix_valid_in(pix_valid_in),
    .pix_sof_in(pix_sof_in),
    .pix_eol_in(pix_eol_in),
    .pix_data_in(pix_data_in),
    .hit(hit),
    .pix_valid_out(pix_valid_out),
    .pix_sof_out(pix_sof_out),
    .pix_eol_out(pix_eol_out),
    .pix_data_out(pix_data_out)
  );

  // outputs straight from the state register
  assign read_index = s_r.idx;
  assign entry_count = s_r.cnt;
  assign read_column = s_r.rcol;
  assign read_row = s_r.rrow;
  assign list_busy = s_r.busy;
  assign nvm_factory_sel = s_r.nv_fact;
  assign nvm_rd_addr = s_r.nv_addr;

  a_count_cap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    entry_count <= LIST_MAX)
    else $error("entry count above capacity");
  a_add_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_IDLE && append_entry_cmd && s_r.cnt == LIST_MAX)
    |=> s_r.st == ST_IDLE && $stable(entry_count))
    else $error("add on full list changed it");
  a_clear_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_IDLE && !append_entry_cmd && !delete_entry_cmd && empty_list_cmd)
    |=> entry_count == '0 && read_index == '0)
    else $error("clear left entries");
  a_zero_readout: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.idx >= s_r.cnt) |=> read_column == '0 && read_row == '0)
    else $error("readout not zero beyond count");
  a_factory_cap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_LDD && s_r.nv_fact) |=> entry_count <= FACT_MAX)
    else $error("factory load above its limit");
  a_add_grows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_SHUP && s_r.j == s_r.pos)
    |=> entry_count == $past(entry_count) + IDX_ONE && read_index == $past(s_r.pos))
    else $error("add did not grow the list");
  // command outcomes, one edge after the engine acts on them
  a_index_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_IDLE && read_index_wr && read_index_in <= IDX_MAX && !append_entry_cmd && !delete_entry_cmd
     && !empty_list_cmd && !load_user_list_cmd && !load_factory_list_cmd)
    |=> read_index == $past(read_index_in))
    else $error("index write not taken");
  a_index_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_IDLE && read_index_wr && read_index_in > IDX_MAX && !empty_list_cmd && !load_factory_list_cmd)
    |=> $stable(read_index))
    else $error("index above range was taken");
  a_add_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_IDLE && append_entry_cmd && !in_rng) |=> !list_busy && $stable(entry_count))
    else $error("out of range add was taken");
  a_remove_shrinks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_SHDN && s_r.j + IDX_ONE == s_r.cnt)
    |=> entry_count == $past(entry_count) - IDX_ONE && read_index == '0)
    else $error("remove did not shrink the list");
  a_factory_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_IDLE && load_factory_list_cmd && !append_entry_cmd && !delete_entry_cmd && !empty_list_cmd
     && !load_user_list_cmd) |=> nvm_factory_sel && entry_count == '0 && read_index == '0)
    else $error("factory load did not start cleanly");
  a_user_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_IDLE && load_user_list_cmd && !append_entry_cmd && !delete_entry_cmd && !empty_list_cmd)
    |=> !nvm_factory_sel && entry_count == '0 && $stable(read_index))
    else $error("user load did not start cleanly");
  a_load_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.st == ST_LDD && s_r.j + IDX_ONE == s_r.nv_n)
    |=> entry_count == $past(s_r.nv_n) && !list_busy)
    else $error("load end did not set the count");
  a_readout_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_r.idx < s_r.cnt)
    |=> read_column == $past(re[COL_W-1:0]) && read_row == $past(re[KEY_W-1:COL_W]))
    else $error("readout does not follow selected entry");
endmodule : dplc_top

// *** testbench/dplc_top_tb.sv ***
// self-checking bench for the defect pixel list block: list commands, readouts and pixel stream
module dplc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dplc_pkg::*;

  logic sys_clk, rst_n, correction_enable, pix_valid_in, pix_sof_in, pix_eol_in;
  logic [1:0] test_display_select;
  logic [COL_W-1:0] array_columns, write_column, read_column;
  logic [ROW_W-1:0] array_rows, write_row, read_row;
  logic append_entry_cmd, delete_entry_cmd, empty_list_cmd, load_user_list_cmd, load_factory_list_cmd;
  logic read_index_wr, list_busy, nvm_factory_sel;
  logic [IDX_W-1:0] read_index_in, read_index, entry_count, nvm_user_count, nvm_factory_count, nvm_rd_addr;
  logic [KEY_W-1:0] nvm_rd_data;
  logic [PIX_W-1:0] pix_data_in;
  logic pix_valid_out, pix_sof_out, pix_eol_out;
  logic [PIX_W-1:0] pix_data_out;
  logic [7:0] listed [3];
  logic [11:0] exp_q [$];
  int error_cnt = 0;
  int num_checks = 0;

  dplc_top dplc_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .correction_enable(correction_enable),
    .test_display_select(test_display_select), .array_columns(array_columns), .array_rows(array_rows),
    .write_column(write_column), .write_row(write_row), .append_entry_cmd(append_entry_cmd),
    .delete_entry_cmd(delete_entry_cmd), .empty_list_cmd(empty_list_cmd),
    .load_user_list_cmd(load_user_list_cmd), .load_factory_list_cmd(load_factory_list_cmd),
    .read_index_wr(read_index_wr), .read_index_in(read_index_in), .read_index(read_index),
    .entry_count(entry_count), .read_column(read_column), .read_row(read_row), .list_busy(list_busy),
    .nvm_user_count(nvm_user_count), .nvm_factory_count(nvm_factory_count),
    .nvm_factory_sel(nvm_factory_sel), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_data(nvm_rd_data),
    .pix_valid_in(pix_valid_in), .pix_sof_in(pix_sof_in), .pix_eol_in(pix_eol_in),
    .pix_data_in(pix_data_in), .pix_valid_out(pix_valid_out), .pix_sof_out(pix_sof_out),
    .pix_eol_out(pix_eol_out), .pix_data_out(pix_data_out)
  );

  // nonvolatile store: factory entries on row 0, user entries on row 1, column = index
  assign nvm_rd_data = {(nvm_factory_sel ? 13'h0000 : 13'h0001), 3'h0, nvm_rd_addr};

  // free-running pixel clock
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // report counts and verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // one comparison with a mismatch line
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // one command pulse, then a bounded wait for the list engine to go idle and readouts to settle
  task automatic cmd(input int which, input logic [COL_W-1:0] col, input logic [ROW_W-1:0] row,
                     input logic [IDX_W-1:0] idx);
    int n;
    @(posedge sys_clk);
    write_column <= col;
    write_row <= row;
    read_index_in <= idx;
    case (which)
      0: append_entry_cmd <= 1'b1;
      1: delete_entry_cmd <= 1'b1;
      2: empty_list_cmd <= 1'b1;
      3: load_user_list_cmd <= 1'b1;
      4: load_factory_list_cmd <= 1'b1;
      default: read_index_wr <= 1'b1;
    endcase
    @(posedge sys_clk);
    {append_entry_cmd, delete_entry_cmd, empty_list_cmd, load_user_list_cmd} <= 4'h0;
    {load_factory_list_cmd, read_index_wr} <= 2'h0;
    @(posedge sys_clk);
    #1;
    for (n = 0; n < 3000 && list_busy !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 3000) chk("busy wait", 32'h0, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : cmd

  // select an index and compare both coordinate readouts
  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [COL_W-1:0] col, input logic [ROW_W-1:0] row);
    cmd(5, 13'h0000, 13'h0000, idx);
    chk("read_column", col, read_column);
    chk("read_row", row, read_row);
  endtask : rd_chk

  // send one 8x3 frame with a gap mid-line and note every expected output pixel
  task automatic frame(input logic [1:0] mode, input logic en);
    logic [PIX_W-1:0] d, o, prev;
    logic hit;
    @(posedge sys_clk);
    test_display_select <= mode;
    correction_enable <= en;
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge sys_clk);
        if (c == 3) begin
          pix_valid_in <= 1'b0;
          @(posedge sys_clk);
        end
        d = PIX_W'($urandom);
        hit = listed[r][c];
        case (mode)
          2'b00: o = (en && hit && c != 0) ? prev : d;
          2'b01: o = hit ? PIX_WHITE : d;
          2'b10: o = hit ? PIX_BLACK : d;
          default: o = hit ? PIX_WHITE : PIX_BLACK;
        endcase
        prev = o;
        pix_valid_in <= 1'b1;
        pix_sof_in <= (r == 0 && c == 0);
        pix_eol_in <= (c == 7);
        pix_data_in <= d;
        exp_q.push_back({(r == 0 && c == 0), (c == 7), o});
      end
    end
    @(posedge sys_clk);
    pix_valid_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : frame

  // output watcher: each valid pixel takes the oldest note
  always @(posedge sys_clk) begin
    if (pix_valid_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected pixel", 32'h0, 32'h1);
      end else begin
        chk("pixel", exp_q.pop_front(), {pix_sof_out, pix_eol_out, pix_data_out});
      end
    end
  end

  // watchdog against a hang
  initial begin
    #3000000;
    error_cnt++;
    $display("MISMATCH watchdog expected done seen running");
    results();
  end

  // main sequence
  initial begin
    {rst_n, correction_enable, pix_valid_in, pix_sof_in, pix_eol_in, read_index_wr} = 6'h00;
    {append_entry_cmd, delete_entry_cmd, empty_list_cmd, load_user_list_cmd, load_factory_list_cmd} = 5'h00;
    test_display_select = 2'b00;
    array_columns = 13'h0008;
    array_rows = 13'h0003;
    {write_column, write_row, read_index_in, pix_data_in} = '0;
    nvm_user_count = 10'h3e8;
    nvm_factory_count = 10'h320;
    listed = '{8'h80, 8'h01, 8'h38};
    void'($urandom(32'h7448));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("entry_count", 32'h0, entry_count);
    // build the list out of order; the list is kept sorted by row then column
    cmd(0, 13'h0005, 13'h0002, 10'h000);
    cmd(0, 13'h0003, 13'h0002, 10'h000);
    cmd(0, 13'h0004, 13'h0002, 10'h000);
    cmd(0, 13'h0000, 13'h0001, 10'h000);
    cmd(0, 13'h0007, 13'h0000, 10'h000);
    chk("read_index", 32'h0, read_index);
    chk("entry_count", 32'h5, entry_count);
    // out-of-range column and row, then a duplicate, are refused
    cmd(0, 13'h0008, 13'h0000, 10'h000);
    cmd(0, 13'h0000, 13'h0003, 10'h000);
    cmd(0, 13'h0003, 13'h0002, 10'h000);
    chk("entry_count", 32'h5, entry_count);
    rd_chk(10'h000, 13'h0007, 13'h0000);
    rd_chk(10'h001, 13'h0000, 13'h0001);
    rd_chk(10'h004, 13'h0005, 13'h0002);
    rd_chk(10'h005, 13'h0000, 13'h0000);
    cmd(5, 13'h0000, 13'h0000, 10'h3e9);
    chk("read_index", 32'h5, read_index);
    rd_chk(IDX_MAX, 13'h0000, 13'h0000);
    chk("read_index", 32'h3e8, read_index);
    // every display mode, plus correction off
    for (int m = 0; m < 5; m++) frame((m < 4) ? 2'(m) : 2'b00, m != 4);
    // remove a present pair, then an absent one
    cmd(1, 13'h0004, 13'h0002, 10'h000);
    cmd(1, 13'h0004, 13'h0002, 10'h000);
    chk("entry_count", 32'h4, entry_count);
    chk("read_index", 32'h0, read_index);
    rd_chk(10'h003, 13'h0005, 13'h0002);
    listed[2] = 8'h28;
    frame(2'b00, 1'b1);
    cmd(2, 13'h0000, 13'h0000, 10'h000);
    chk("entry_count", 32'h0, entry_count);
    chk("read_index", 32'h0, read_index);
    // factory load longer than its cap
    cmd(4, 13'h0000, 13'h0000, 10'h000);
    chk("entry_count", 32'h2bc, entry_count);
    chk("read_index", 32'h0, read_index);
    rd_chk(10'h2bb, 13'h02bb, 13'h0000);
    // user load fills the list; index is left where it was
    cmd(3, 13'h0000, 13'h0000, 10'h000);
    chk("entry_count", 32'h3e8, entry_count);
    chk("read_index", 32'h2bb, read_index);
    rd_chk(10'h3e7, 13'h03e7, 13'h0001);
    cmd(0, 13'h0005, 13'h0002, 10'h000);
    chk("entry_count", 32'h3e8, entry_count);
    chk("pending pixels", 32'h0, exp_q.size());
    results();
  end
endmodule : dplc_top_tb
